// *** shared/supply_monitor_pkg.sv ***
// Shared constants of the supply monitor block
package supply_monitor_pkg;
    // ============================================================
    // Register address and layout
    localparam logic [7:0] SUPPLY_MONITOR_CONTROL_ADDR = 8'hDF;
    localparam logic [7:0] SUPPLY_MONITOR_CONTROL_RESET = 8'hDC;
    localparam int CMP_STATE_BIT = 6;
    localparam int IRQ_FLAG_BIT = 5;
    localparam int THRESH_HI_BIT = 4;
    localparam int THRESH_LO_BIT = 2;
    localparam int FAULT_SRC_BIT = 1;
    localparam int ENABLE_BIT = 0;
    // ============================================================
    // Threshold codes
    localparam logic [2:0] THRESH_4V63 = 3'h0;
    localparam logic [2:0] THRESH_4V37 = 3'h1;
    localparam logic [2:0] THRESH_3V08 = 3'h2;
    localparam logic [2:0] THRESH_2V93 = 3'h3;
    localparam logic [2:0] THRESH_2V63 = 3'h4;
    // ============================================================
    // Timing
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int HOLDOFF_MS = 256;
    localparam longint HOLDOFF_CYCLES_L = longint'(CLK_FREQ_HZ) / 1000 * HOLDOFF_MS;
    localparam logic [31:0] HOLDOFF_CYCLES = HOLDOFF_CYCLES_L[31:0];
    localparam int GLITCH_CYCLES = 4;
    localparam logic [2:0] GLITCH_LAST = 3'(GLITCH_CYCLES - 1);
endpackage : supply_monitor_pkg

// *** shared/comp_filter_if.sv ***
// Carrier between a comparator filter and the monitor core
`timescale 1ns/1ps
interface comp_filter_if;
    logic raw;
    logic clean;
    modport filter (input raw, output clean);
    modport core (output raw, input clean);
endinterface : comp_filter_if

// *** rtl/comp_glitch_filter.sv ***
// Synchroniser and glitch filter for one supply comparator
`timescale 1ns/1ps
module comp_glitch_filter
    import supply_monitor_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    comp_filter_if.filter port_if
);
    logic sync1_reg;
    logic sync2_reg;
    logic [2:0] stable_cnt_reg;
    logic clean_reg;

    // ============================================================
    // Two-stage synchroniser, idle state is supply good
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end
        else
        begin
            sync1_reg <= port_if.raw;
            sync2_reg <= sync1_reg;
        end
    end

    // ============================================================
    // Output follows only a level held for the whole filter time
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            stable_cnt_reg <= 3'h0;
            clean_reg <= 1'b1;
        end
        else if (sync2_reg == clean_reg)
        begin
            stable_cnt_reg <= 3'h0;
        end
        else if (stable_cnt_reg == GLITCH_LAST)
        begin
            stable_cnt_reg <= 3'h0;
            clean_reg <= sync2_reg;
        end
        else
        begin
            stable_cnt_reg <= stable_cnt_reg + 3'h1;
        end
    end

    assign port_if.clean = clean_reg;
endmodule : comp_glitch_filter

// *** rtl/supply_voltage_monitor.sv ***
// Control and status logic of the supply voltage monitor
`timescale 1ns/1ps
// What this block does
// - When enabled, flag low analog or digital supply
// - Three-bit field selects comparator trip level
// - Bit 6 read-only shows combined comparator state
// - Hardware sets flag bit 5 while compare low
// - Flag clears after 256 ms continuously high
// - Software clear ignored while any comparator low
// - Interrupt raised only when separately enabled
// - Bit 1 tells analog or digital fault
// - Brief comparator glitches are filtered out
module supply_voltage_monitor
    import supply_monitor_pkg::*;
#(
    parameter logic [31:0] HOLDOFF_COUNT = HOLDOFF_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_analog_ok,
    input wire logic i_digital_ok,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_irq_enable,
    output logic [7:0] o_sfr_rdata,
    output logic [2:0] o_threshold_sel,
    output logic o_monitor_enable,
    output logic o_irq
);
    comp_filter_if analog_if ();
    comp_filter_if digital_if ();

    logic monitor_enable_reg;
    logic [2:0] threshold_sel_reg;
    logic supply_fault_irq_flag_reg;
    logic fault_source_flag_reg;
    logic supply_compare_state_reg;
    logic [31:0] holdoff_cnt_reg;
    logic irq_reg;
    logic [7:0] rdata_reg;
    // Hold-off phases
    typedef enum logic [1:0] {PHASE_CLEAR, PHASE_LOW, PHASE_SETTLE} holdoff_phase_t;
    holdoff_phase_t phase_reg;
    holdoff_phase_t phase_next;
    logic [7:0] read_value;
    logic analog_low;
    logic digital_low;
    logic any_low;
    logic reg_write;
    logic holdoff_done;

    // ============================================================
    // Comparator filtering, one instance per supply
    assign analog_if.raw = i_analog_ok;
    assign digital_if.raw = i_digital_ok;

    comp_glitch_filter u_analog_filter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .port_if(analog_if.filter)
    );

    comp_glitch_filter u_digital_filter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .port_if(digital_if.filter)
    );

    // Faults only count while the monitor is enabled
    assign analog_low = monitor_enable_reg & ~analog_if.clean;
    assign digital_low = monitor_enable_reg & ~digital_if.clean;
    assign any_low = analog_low | digital_low;

    // Write decode and end of the hold-off count
    assign reg_write = i_sfr_wr && (i_sfr_addr == SUPPLY_MONITOR_CONTROL_ADDR);
    assign holdoff_done = (holdoff_cnt_reg == HOLDOFF_COUNT - 32'h1);

    // ============================================================
    // Software-owned fields: enable and trip point
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            monitor_enable_reg <= SUPPLY_MONITOR_CONTROL_RESET[ENABLE_BIT];
            threshold_sel_reg <= SUPPLY_MONITOR_CONTROL_RESET[THRESH_HI_BIT:THRESH_LO_BIT];
        end
        else if (reg_write)
        begin
            monitor_enable_reg <= i_sfr_wdata[ENABLE_BIT];
            threshold_sel_reg <= i_sfr_wdata[THRESH_HI_BIT:THRESH_LO_BIT];
        end
    end

    // ============================================================
    // Combined comparator state, low when either supply is low while the monitor is enabled
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            supply_compare_state_reg <= SUPPLY_MONITOR_CONTROL_RESET[CMP_STATE_BIT];
        else
            supply_compare_state_reg <= ~any_low;
    end

    // ============================================================
    // Hold-off phase: flag clear, supply low, or settling after return
    always_comb
    begin
        phase_next = phase_reg;
        case (phase_reg)
            PHASE_CLEAR:
            begin
                if (any_low)
                    phase_next = PHASE_LOW;
                else if (supply_fault_irq_flag_reg)
                    phase_next = PHASE_SETTLE;
            end
            PHASE_LOW:
            begin
                if (!any_low)
                    phase_next = PHASE_SETTLE;
            end
            PHASE_SETTLE:
            begin
                if (any_low)
                    phase_next = PHASE_LOW;
                else if (!supply_fault_irq_flag_reg || holdoff_done)
                    phase_next = PHASE_CLEAR;
            end
            default:
                phase_next = PHASE_CLEAR;
        endcase
    end

    // Phase register
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            phase_reg <= PHASE_CLEAR;
        else
            phase_reg <= phase_next;
    end

    // ============================================================
    // Hold-off counter, runs only while settling with both supplies good and flag set
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            holdoff_cnt_reg <= 32'h0;
        else if (phase_reg != PHASE_SETTLE || any_low || !supply_fault_irq_flag_reg || holdoff_done)
            holdoff_cnt_reg <= 32'h0;
        else
            holdoff_cnt_reg <= holdoff_cnt_reg + 32'h1;
    end

    // ============================================================
    // Interrupt flag: set wins over any clear
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            supply_fault_irq_flag_reg <= SUPPLY_MONITOR_CONTROL_RESET[IRQ_FLAG_BIT];
        else if (any_low)
            supply_fault_irq_flag_reg <= 1'b1;
        else if (reg_write)
            supply_fault_irq_flag_reg <= i_sfr_wdata[IRQ_FLAG_BIT];
        else if (supply_fault_irq_flag_reg && holdoff_done)
            supply_fault_irq_flag_reg <= 1'b0;
    end

    // ============================================================
    // Fault source: analog takes precedence when both fail
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            fault_source_flag_reg <= SUPPLY_MONITOR_CONTROL_RESET[FAULT_SRC_BIT];
        else if (analog_low)
            fault_source_flag_reg <= 1'b1;
        else if (digital_low)
            fault_source_flag_reg <= 1'b0;
    end

    // ============================================================
    // Interrupt request gated by the enable bit, which shares this clock and needs no synchroniser
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            irq_reg <= 1'b0;
        else
            irq_reg <= supply_fault_irq_flag_reg & i_irq_enable;
    end

    // ============================================================
    // Read value assembled field by field, unused bit keeps its reset value
    always_comb
    begin
        read_value = SUPPLY_MONITOR_CONTROL_RESET;
        read_value[CMP_STATE_BIT] = supply_compare_state_reg;
        read_value[IRQ_FLAG_BIT] = supply_fault_irq_flag_reg;
        read_value[THRESH_HI_BIT:THRESH_LO_BIT] = threshold_sel_reg;
        read_value[FAULT_SRC_BIT] = fault_source_flag_reg;
        read_value[ENABLE_BIT] = monitor_enable_reg;
    end

    // ============================================================
    // Registered read data, so the value seen after reset never jumps
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rdata_reg <= SUPPLY_MONITOR_CONTROL_RESET;
        else
            rdata_reg <= read_value;
    end

    // Outputs straight from flip-flops
    assign o_sfr_rdata = rdata_reg;
    assign o_threshold_sel = threshold_sel_reg;
    assign o_monitor_enable = monitor_enable_reg;
    assign o_irq = irq_reg;
endmodule : supply_voltage_monitor

// *** tb/svm_asserts.sv ***
// Port checker for the supply voltage monitor
`timescale 1ns/1ps
module svm_asserts
    import supply_monitor_pkg::*;
#(
    parameter logic [31:0] HOLDOFF_COUNT = HOLDOFF_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_analog_ok,
    input wire logic i_digital_ok,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_irq_enable,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic [2:0] o_threshold_sel,
    input wire logic o_monitor_enable,
    input wire logic o_irq
);
// =====
// Helpers
logic [31:0] good_run;
logic [2:0] wr_hist;
logic hit;
assign hit = i_sfr_wr && i_sfr_addr == SUPPLY_MONITOR_CONTROL_ADDR;
// Length of the current run of good comparator readings
always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) good_run <= '0;
    else good_run <= o_sfr_rdata[6] ? good_run + 32'h1 : '0;
// Recent writes, which may clear the flag early
always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) wr_hist <= '0;
    else wr_hist <= {wr_hist[1:0], i_sfr_wr};
// =====
// Assertions
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
a_irq_needs_en: assert property ((!i_irq_enable) [*5] |-> !o_irq) else $error("irq while disabled");
a_irq_from_flag: assert property (o_irq |-> o_sfr_rdata[5] || $past(o_sfr_rdata[5]))
    else $error("irq without flag");
a_unused_bit: assert property (o_sfr_rdata[7] == SUPPLY_MONITOR_CONTROL_RESET[7]) else $error("bit 7 changed");
a_low_keeps_flag: assert property ((!o_sfr_rdata[6]) [*3] |-> o_sfr_rdata[5]) else $error("flag lost");
a_good_shows_cmp: assert property ((i_analog_ok && i_digital_ok) [*8] |-> ##[0:4] o_sfr_rdata[6])
    else $error("cmp stuck low");
a_wr_enable: assert property (hit |=> o_monitor_enable == $past(i_sfr_wdata[0])) else $error("enable");
a_wr_thresh: assert property (hit |=> o_threshold_sel == $past(i_sfr_wdata[4:2])) else $error("thresh");
a_other_addr: assert property (i_sfr_wr && !hit |=> $stable(o_threshold_sel)) else $error("decode");
a_holdoff_len: assert property ($fell(o_sfr_rdata[5]) && wr_hist == 3'h0 |-> good_run >= HOLDOFF_COUNT - 2)
    else $error("early clear");
c_irq: cover property (o_irq);
c_analog_fault: cover property (!o_sfr_rdata[6] && o_sfr_rdata[1]);
c_clear: cover property ($fell(o_sfr_rdata[5]));
endmodule : svm_asserts
bind supply_voltage_monitor svm_asserts #(.HOLDOFF_COUNT(HOLDOFF_COUNT)) u_chk (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_analog_ok(i_analog_ok), .i_digital_ok(i_digital_ok), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_irq_enable(i_irq_enable), .o_sfr_rdata(o_sfr_rdata),
    .o_threshold_sel(o_threshold_sel), .o_monitor_enable(o_monitor_enable), .o_irq(o_irq));

// *** tb/core_model.sv ***
// Behavioural processor core writing the control register
`timescale 1ns/1ps
module core_model
(
    input wire logic i_clk,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata
);
// Single-cycle write; released lines show inverted values
task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    #1;
    o_addr = addr;
    o_wdata = data;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_addr = ~addr;
    o_wdata = ~data;
endtask : sfr_write
// Idle bus at time zero
initial
begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
end
endmodule : core_model

// *** tb/tb_top.sv ***
// Self-checking bench of the supply voltage monitor
`timescale 1ns/1ps
module tb_top
    import supply_monitor_pkg::*;
;
localparam logic [31:0] HOLD = 32'h28;
logic i_clk = 1'b0;
logic i_rst_n = 1'b0;
logic i_analog_ok = 1'b1;
logic i_digital_ok = 1'b1;
logic i_irq_enable = 1'b0;
logic [7:0] addr, wdata, rdata;
logic wr, irq, en;
logic [2:0] thr;
int num_errors = 0;
int tests_run = 0;
int seed = 32'h32296E7C;
int n;
// Clock, partner and device
always #5 i_clk = ~i_clk;
core_model i_core (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata));
supply_voltage_monitor #(.HOLDOFF_COUNT(HOLD)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_analog_ok(i_analog_ok),
    .i_digital_ok(i_digital_ok), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_irq_enable(i_irq_enable),
    .o_sfr_rdata(rdata), .o_threshold_sel(thr), .o_monitor_enable(en), .o_irq(irq));
// =====
// Helpers
function automatic logic [7:0] exp_reg(input logic c, input logic f, input logic [2:0] t, input logic s, input logic e);
    return {SUPPLY_MONITOR_CONTROL_RESET[7], c, f, t, s, e};
endfunction : exp_reg
task automatic chk(input logic [8:0] seen, input logic [8:0] want);
    tests_run++;
    if (seen !== want)
    begin
        num_errors++;
        $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
endtask : chk
task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask : complete_run
task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
endtask : cyc
// Bounded wait for the flag to reach a level, counting cycles
task automatic wait_flag(input logic v, output int c);
    c = 0;
    while (rdata[5] !== v)
    begin
        cyc(1);
        c++;
        if (c > 500)
        begin
            num_errors++;
            complete_run();
        end
    end
endtask : wait_flag
// =====
// Main sequence
initial
begin
    cyc(8);
    chk({1'b0, rdata}, {1'b0, SUPPLY_MONITOR_CONTROL_RESET});
    chk({5'h0, en, thr}, 9'h07);
    i_rst_n = 1'b1;
    // Every threshold code, flag cleared while supplies are good, stray writes between
    for (int c = 0; c < 5; c++)
    begin
        i_core.sfr_write(SUPPLY_MONITOR_CONTROL_ADDR, {3'h0, 3'(c), 2'h3});
        i_core.sfr_write({1'b0, 7'($random(seed))}, 8'($random(seed)));
        cyc(2);
        chk({irq, rdata}, {1'b0, exp_reg(1'b1, 1'b0, 3'(c), 1'b0, 1'b1)});
        chk({5'h0, en, thr}, {5'h0, 1'b1, 3'(c)});
    end
    // Dip shorter than the filter leaves the flag alone
    i_irq_enable = 1'b1;
    i_analog_ok = 1'b0;
    cyc(1 + ($unsigned($random(seed)) % 3));
    i_analog_ok = 1'b1;
    cyc(12);
    chk({irq, rdata}, {1'b0, exp_reg(1'b1, 1'b0, 3'h4, 1'b0, 1'b1)});
    // Analog fault with interrupt enabled, then digital fault without
    for (int s = 1; s >= 0; s--)
    begin
        i_irq_enable = s[0];
        {i_analog_ok, i_digital_ok} = {!s[0], s[0]};
        wait_flag(1'b1, n);
        cyc(3);
        chk({irq, rdata}, {s[0], exp_reg(1'b0, 1'b1, 3'h4, s[0], 1'b1)});
        i_core.sfr_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h11);
        cyc(2);
        chk({irq, rdata}, {s[0], exp_reg(1'b0, 1'b1, 3'h4, s[0], 1'b1)});
        {i_analog_ok, i_digital_ok} = 2'h3;
        cyc(HOLD / 2);
        {i_analog_ok, i_digital_ok} = {!s[0], s[0]};
        cyc(8 + ($unsigned($random(seed)) % 8));
        {i_analog_ok, i_digital_ok} = 2'h3;
        wait_flag(1'b0, n);
        chk(9'(n >= HOLD && n <= HOLD + 14), 9'h1);
        cyc(2);
        chk({irq, rdata & 8'hFD}, {1'b0, exp_reg(1'b1, 1'b0, 3'h4, 1'b0, 1'b1)});
    end
    // Software sets the flag, then clears it while supplies are good
    i_core.sfr_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h31);
    cyc(2);
    chk({irq, rdata}, {1'b0, exp_reg(1'b1, 1'b1, 3'h4, 1'b0, 1'b1)});
    i_core.sfr_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h11);
    cyc(2);
    chk({irq, rdata}, {1'b0, exp_reg(1'b1, 1'b0, 3'h4, 1'b0, 1'b1)});
    // Disabled monitor ignores a low supply
    i_core.sfr_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h10);
    i_analog_ok = 1'b0;
    cyc(20);
    chk({en, rdata & 8'hFD}, {1'b0, exp_reg(1'b1, 1'b0, 3'h4, 1'b0, 1'b0)});
    complete_run();
end
endmodule : tb_top
